// ===== hdl/ubfc_defines.svh
// Constants for the serial port buffering, flow control and checksum block.
`ifndef UBFC_DEFINES_SVH
`define UBFC_DEFINES_SVH
`define UBFC_XOFF_CHAR   8'h13
`define UBFC_XON_CHAR    8'h11
`define UBFC_FLOW_NONE   2'h0
`define UBFC_FLOW_XONOFF 2'h1
`define UBFC_FLOW_HW     2'h2
`define UBFC_RX_DEPTH    2'h2
`endif

// ===== hdl/ubfc_pkg.sv
// Types for the serial port buffering, flow control and checksum block.
package ubfc_pkg;
    typedef enum logic [1:0] {UBFC_ASYNC, UBFC_LIN, UBFC_DALI, UBFC_DMX} ubfc_mode_t;
    typedef struct packed {
        logic       moduleOn;
        logic       txEnable;
        logic       rxEnable;
        logic       runDuringOverflow;
        logic [1:0] flowSelect;
        logic       checksumEnable;
        ubfc_mode_t mode;
    } ubfc_cfg_t;
    typedef struct packed {
        logic rxEmpty;
        logic rxFull;
        logic txEmpty;
        logic txFull;
        logic txWriteError;
        logic xonState;
        logic rxOverflowFlag;
        logic collisionFlag;
    } ubfc_status_t;
endpackage : ubfc_pkg

// ===== hdl/uart_buffer_flow_checksum.sv
// Buffering, flushing, flow control, checksum and collision logic of a serial port.
//
// Overview of operation
// - With run-during-overflow set, the receive shifter keeps framing words during overflow.
// - With it clear, the receive shifter halts during overflow and loses alignment.
// - Receive side has shifter plus two-entry buffer; reads return the oldest byte.
// - One transmit holding buffer; writes pass to an empty shifter, else wait.
// - Receive-empty is inverse of receive flag; receive-full when both entries hold data.
// - Transmit-empty equals transmit flag; transmit-full is its inverse.
// - Writing a full transmit buffer sets sticky write error and is dropped.
// - Writing one to receive-empty flushes all unread receive bytes.
// - Bytes written with transmit disabled wait in the shifter, then the holding buffer, until enabled.
// - Setting transmit-empty flushes buffer and idle shifter, not an active character.
// - Clearing module enable discards received data and pending transmit data.
// - Flow select 00 off, 10 hardware, 01 XON/XOFF; inactive in LIN/DALI/DMX.
// - With hardware flow, drive enable is high only while a character is actively being sent; low in other settings.
// - With hardware flow, ready-to-send low while receive buffer empty, high from arrival until emptied; low in other settings.
// - A character begun before clear-to-send drops finishes and is accepted.
// - With XON/XOFF, receiving 13h stops sending after current character until 11h arrives.
// - Transmitter starts resumed, shown as status; toggling transmit enable resumes.
// - Flow characters act during overflow only with run-during-overflow set.
// - Checksum enable makes both accumulators add every byte, carry included, not LIN.
// - With receive and transmit enabled, a mismatched echoed word sets collision flag.
// - In DALI transmissions a missing mid-bit transition also sets collision flag.
`timescale 1ns/1ps
`include "ubfc_defines.svh"
module uart_buffer_flow_checksum (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Configuration and software strobes
    input  wire ubfc_pkg::ubfc_cfg_t   cfg,
    input  wire logic                  txWrite,
    input  wire logic [7:0]            txWriteData,
    input  wire logic                  rxRead,
    input  wire logic                  rxFlush,
    input  wire logic                  txFlush,
    input  wire logic                  clearTxWriteError,
    input  wire logic                  clearOverflow,
    input  wire logic                  clearCollision,
    input  wire logic                  clearTxChecksum,
    input  wire logic                  clearRxChecksum,
    // Framing engine side
    input  wire logic                  rxWordDone,
    input  wire logic [7:0]            rxWord,
    input  wire logic                  txCharDone,
    input  wire logic                  daliMidBitMissing,
    output logic                       rxShiftRun,
    output logic                       txStart,
    output logic [7:0]                 txShiftData,
    output logic                       txActive,
    // Pins
    input  wire logic                  ctsN,
    output logic                       rtsN,
    output logic                       txDriveEnable,
    // Software view
    output logic [7:0]                 rxData,
    output logic [7:0]                 txChecksum,
    output logic [7:0]                 rxChecksum,
    output ubfc_pkg::ubfc_status_t     status
);
    // ==========================================================
    // State
    // ==========================================================
    logic [7:0] rxMem [0:1];
    logic [7:0] next_rxMem [0:1];
    logic [1:0] rxCount, next_rxCount;
    logic       rxHead, next_rxHead;
    logic [7:0] txBuf, next_txBuf;
    logic       txBufFull, next_txBufFull;
    logic [7:0] txShift, next_txShift;
    logic       txShiftFull, next_txShiftFull;
    logic       txBusy, next_txBusy;
    logic [7:0] lastTxWord, next_lastTxWord;
    logic       echoPending, next_echoPending;
    logic       xon, next_xon;
    logic       txEnPrev, next_txEnPrev;
    logic       writeErr, next_writeErr;
    logic       overflow, next_overflow;
    logic       collision, next_collision;
    logic [7:0] txSum, next_txSum;
    logic [7:0] rxSum, next_rxSum;
    logic       rtsHigh, next_rtsHigh;
    logic [7:0] rxDataQ, next_rxDataQ;

    // Adds a byte with end-around carry so the carry stays in the sum.
    function automatic logic [7:0] ubfc_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction : ubfc_add

    // ==========================================================
    // Decodes
    // ==========================================================
    logic flowAllowed, hwFlow, swFlow, rxFullNow, storeOk, flowSeen, startNow;
    logic popOk, txWriteOk;
    always_comb begin
        flowAllowed = cfg.mode == ubfc_pkg::UBFC_ASYNC;
        hwFlow      = flowAllowed && cfg.flowSelect == `UBFC_FLOW_HW;
        swFlow      = flowAllowed && cfg.flowSelect == `UBFC_FLOW_XONOFF;
        rxFullNow   = rxCount == `UBFC_RX_DEPTH;
        // Legacy mode freezes the shifter while an overflow is pending.
        rxShiftRun  = cfg.moduleOn && cfg.rxEnable
                      && (cfg.runDuringOverflow || !overflow);
        storeOk     = rxWordDone && rxShiftRun;
        flowSeen    = storeOk && swFlow;
        popOk       = rxRead && rxCount != 2'h0;
        txWriteOk   = txWrite && !txBufFull;
        startNow    = cfg.moduleOn && cfg.txEnable && txShiftFull && !txBusy
                      && (!hwFlow || !ctsN) && (!swFlow || xon);
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_rxMem      = rxMem;
        next_rxCount    = rxCount;
        next_rxHead     = rxHead;
        next_txBuf      = txBuf;
        next_txBufFull  = txBufFull;
        next_txShift    = txShift;
        next_txShiftFull= txShiftFull;
        next_txBusy     = txBusy;
        next_lastTxWord = lastTxWord;
        next_echoPending= echoPending;
        next_xon        = xon;
        next_txEnPrev   = cfg.txEnable;
        next_writeErr   = writeErr;
        next_overflow   = overflow;
        next_collision  = collision;
        next_txSum      = txSum;
        next_rxSum      = rxSum;
        next_rtsHigh    = rtsHigh;
        next_rxDataQ    = rxDataQ;

        // Receive FIFO.
        if (popOk) begin
            next_rxHead  = ~rxHead;
            next_rxCount = rxCount - 2'h1;
        end
        if (storeOk) begin
            if (rxFullNow && !popOk) begin
                next_overflow = 1'b1;
            end else begin
                next_rxMem[rxHead ^ rxCount[0]] = rxWord;
                next_rxCount = next_rxCount + 2'h1;
            end
            if (cfg.checksumEnable && cfg.mode != ubfc_pkg::UBFC_LIN) begin
                next_rxSum = ubfc_add(rxSum, rxWord);
            end
            if (echoPending && cfg.txEnable) begin
                next_echoPending = 1'b0;
                if (rxWord != lastTxWord) begin
                    next_collision = 1'b1;
                end
            end
        end
        if (flowSeen && rxWord == `UBFC_XOFF_CHAR) begin
            next_xon = 1'b0;
        end
        if (flowSeen && rxWord == `UBFC_XON_CHAR) begin
            next_xon = 1'b1;
        end
        if (cfg.txEnable != txEnPrev) begin
            next_xon = 1'b1;
        end
        if (rxFlush) begin
            next_rxCount = 2'h0;
            next_rxHead  = 1'b0;
        end
        next_rxDataQ = next_rxMem[next_rxHead];

        // Ready-to-send rises on arrival and falls only once empty.
        if (next_rxCount != 2'h0) begin
            next_rtsHigh = 1'b1;
        end else begin
            next_rtsHigh = 1'b0;
        end

        // Transmit path.
        if (txCharDone && txBusy) begin
            next_txBusy      = 1'b0;
            next_txShiftFull = 1'b0;
        end
        if (startNow) begin
            next_txBusy     = 1'b1;
            next_lastTxWord = txShift;
            next_echoPending= cfg.rxEnable;
            if (cfg.checksumEnable && cfg.mode != ubfc_pkg::UBFC_LIN) begin
                next_txSum = ubfc_add(txSum, txShift);
            end
        end
        if (!next_txShiftFull && next_txBufFull) begin
            next_txShift     = txBuf;
            next_txShiftFull = 1'b1;
            next_txBufFull   = 1'b0;
        end
        if (txWriteOk) begin
            if (!next_txShiftFull) begin
                next_txShift     = txWriteData;
                next_txShiftFull = 1'b1;
            end else begin
                next_txBuf     = txWriteData;
                next_txBufFull = 1'b1;
            end
        end
        if (txFlush) begin
            next_txBufFull = 1'b0;
            if (!next_txBusy) begin
                next_txShiftFull = 1'b0;
            end
        end

        // Sticky flags: a set in the same cycle beats the clear.
        if (clearTxWriteError) next_writeErr = 1'b0;
        if (txWrite && txBufFull) next_writeErr = 1'b1;
        if (clearOverflow) next_overflow = 1'b0;
        if (storeOk && rxFullNow && !popOk) next_overflow = 1'b1;
        if (clearCollision) next_collision = 1'b0;
        if (storeOk && echoPending && cfg.txEnable && rxWord != lastTxWord) begin
            next_collision = 1'b1;
        end
        if (daliMidBitMissing && txBusy && cfg.mode == ubfc_pkg::UBFC_DALI) begin
            next_collision = 1'b1;
        end
        if (clearTxChecksum) next_txSum = 8'h00;
        if (clearRxChecksum) next_rxSum = 8'h00;

        // Module disable acts as a soft reset of the data paths.
        if (!cfg.moduleOn) begin
            next_rxCount     = 2'h0;
            next_rxHead      = 1'b0;
            next_txBufFull   = 1'b0;
            next_txShiftFull = 1'b0;
            next_txBusy      = 1'b0;
            next_echoPending = 1'b0;
            next_rtsHigh     = 1'b0;
            next_xon         = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxMem[0]    <= 8'h00;
            rxMem[1]    <= 8'h00;
            rxCount     <= 2'h0;
            rxHead      <= 1'b0;
            txBuf       <= 8'h00;
            txBufFull   <= 1'b0;
            txShift     <= 8'h00;
            txShiftFull <= 1'b0;
            txBusy      <= 1'b0;
            lastTxWord  <= 8'h00;
            echoPending <= 1'b0;
            xon         <= 1'b1;
            txEnPrev    <= 1'b0;
            writeErr    <= 1'b0;
            overflow    <= 1'b0;
            collision   <= 1'b0;
            txSum       <= 8'h00;
            rxSum       <= 8'h00;
            rtsHigh     <= 1'b0;
            rxDataQ     <= 8'h00;
        end else begin
            rxMem       <= next_rxMem;
            rxCount     <= next_rxCount;
            rxHead      <= next_rxHead;
            txBuf       <= next_txBuf;
            txBufFull   <= next_txBufFull;
            txShift     <= next_txShift;
            txShiftFull <= next_txShiftFull;
            txBusy      <= next_txBusy;
            lastTxWord  <= next_lastTxWord;
            echoPending <= next_echoPending;
            xon         <= next_xon;
            txEnPrev    <= next_txEnPrev;
            writeErr    <= next_writeErr;
            overflow    <= next_overflow;
            collision   <= next_collision;
            txSum       <= next_txSum;
            rxSum       <= next_rxSum;
            rtsHigh     <= next_rtsHigh;
            rxDataQ     <= next_rxDataQ;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    always_comb begin
        txStart               = startNow;
        txShiftData           = txShift;
        txActive              = txBusy;
        txDriveEnable         = hwFlow && txBusy;
        rtsN                  = hwFlow && rtsHigh;
        rxData                = rxDataQ;
        txChecksum            = txSum;
        rxChecksum            = rxSum;
        status.rxEmpty        = rxCount == 2'h0;
        status.rxFull         = rxFullNow;
        status.txEmpty        = !txBufFull;
        status.txFull         = txBufFull;
        status.txWriteError   = writeErr;
        status.xonState       = xon;
        status.rxOverflowFlag = overflow;
        status.collisionFlag  = collision;
    end
endmodule : uart_buffer_flow_checksum

// ===== tb/ubfc_asserts.sv
// Port-level checks of the serial port buffering and flow control block.
`timescale 1ns/1ps
module ubfc_asserts (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   nrst,
    // Block inputs
    input wire ubfc_pkg::ubfc_cfg_t    cfg,
    input wire logic                   txWrite,
    input wire logic                   rxFlush,
    input wire logic                   clearTxWriteError,
    input wire logic                   rxWordDone,
    input wire logic                   ctsN,
    // Block outputs
    input wire logic                   txStart,
    input wire logic                   txActive,
    input wire logic                   rtsN,
    input wire logic                   txDriveEnable,
    input wire ubfc_pkg::ubfc_status_t status
);
    // ========================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic async;
    assign async = cfg.mode == ubfc_pkg::UBFC_ASYNC;

    a_tx_status_pair: assert property (status.txFull != status.txEmpty)
        else $error("tx full and tx empty not complementary");
    a_rx_full_empty: assert property (status.rxFull |-> !status.rxEmpty)
        else $error("rx full while rx empty");
    a_write_err_sticky: assert property (txWrite && status.txFull && !clearTxWriteError
        |=> status.txWriteError)
        else $error("write to full buffer not flagged");
    a_rx_flush_empty: assert property (rxFlush && !rxWordDone |=> status.rxEmpty)
        else $error("rx flush left data");
    a_start_enabled: assert property (txStart |-> (cfg.moduleOn && cfg.txEnable) ##1 txActive)
        else $error("start without enable or no active phase");
    a_start_cts_low: assert property (txStart && cfg.flowSelect == 2'h2 && async |-> !ctsN)
        else $error("start while clear to send deasserted");
    a_xoff_no_start: assert property (!status.xonState && cfg.flowSelect == 2'h1 && async
        |-> !txStart)
        else $error("start while suspended");
    a_drive_active: assert property (cfg.flowSelect == 2'h2 && async |-> txDriveEnable == txActive)
        else $error("drive enable differs from active character");
    a_rts_rx_count: assert property (cfg.flowSelect == 2'h2 && async |-> rtsN == !status.rxEmpty)
        else $error("ready to send wrong for rx fill");
    a_off_flushes: assert property ($fell(cfg.moduleOn) |=> status.rxEmpty && status.txEmpty)
        else $error("module off kept data");

    c_overflow: cover property ($rose(status.rxOverflowFlag));
    c_collision: cover property ($rose(status.collisionFlag));
    c_write_refused: cover property (txWrite && status.txFull);
endmodule : ubfc_asserts

bind uart_buffer_flow_checksum ubfc_asserts u_asserts (
    .clk(clk), .nrst(nrst), .cfg(cfg), .txWrite(txWrite), .rxFlush(rxFlush),
    .clearTxWriteError(clearTxWriteError), .rxWordDone(rxWordDone), .ctsN(ctsN),
    .txStart(txStart), .txActive(txActive), .rtsN(rtsN), .txDriveEnable(txDriveEnable),
    .status(status));

// ===== tb/ubfc_partner.sv
// Far-side model: remote serial port together with the framing engine.
`timescale 1ns/1ps
module ubfc_partner #(
    parameter int CHAR_CYCLES = 4
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Block side
    input  wire logic       txStart,
    input  wire logic [7:0] txShiftData,
    input  wire logic       ctsN,
    output logic            rxWordDone,
    output logic [7:0]      rxWord,
    output logic            txCharDone,
    // Bench control
    input  wire logic       sendReq,
    input  wire logic [7:0] sendByte,
    input  wire logic       echo,
    input  wire logic       corrupt,
    output logic [7:0]      lastTx
);
    int cnt;
    // Between words the data toggles, so a stale byte can never pass for a fresh one.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt        <= 0;
            rxWordDone <= 1'b0;
            txCharDone <= 1'b0;
            rxWord     <= 8'h00;
            lastTx     <= 8'h00;
        end else begin
            // A word only begins while our clear-to-send is low; one begun still completes.
            rxWordDone <= sendReq && !ctsN;
            rxWord     <= sendReq ? sendByte : ~rxWord;
            txCharDone <= cnt == 1;
            cnt        <= cnt > 0 ? cnt - 1 : 0;
            if (txStart) begin
                lastTx <= txShiftData;
                cnt    <= CHAR_CYCLES;
            end
            if (cnt == 1 && echo) begin
                rxWordDone <= 1'b1;
                rxWord     <= lastTx ^ {7'h00, corrupt};
            end
        end
    end
endmodule : ubfc_partner

// ===== tb/uart_buffer_flow_checksum_test.sv
// Self-checking bench for the serial port buffering and flow control block.
`timescale 1ns/1ps
module uart_buffer_flow_checksum_test;
    logic                   clk = 1'b0;
    logic                   nrst = 1'b0;
    ubfc_pkg::ubfc_cfg_t    cfg = '0;
    logic                   txWrite = 1'b0, rxRead = 1'b0, rxFlush = 1'b0, txFlush = 1'b0;
    logic                   clrWriteErr = 1'b0, clrOvf = 1'b0, clrCol = 1'b0;
    logic                   clrTxSum = 1'b0, clrRxSum = 1'b0, daliMiss = 1'b0, ctsN = 1'b0;
    logic                   sendReq = 1'b0, echo = 1'b0, corrupt = 1'b0;
    logic [7:0]             txData = 8'h00, sendByte = 8'h00;
    logic                   rxWordDone, txCharDone, rxShiftRun, txStart, txActive, rtsN, tx_drive_enable;
    logic [7:0]             rxWord, txShiftData, rxData, txSum, rxSum, lastTx;
    ubfc_pkg::ubfc_status_t status;
    int                     failCount = 0;
    int                     comparisons = 0;

    always #25 clk = ~clk;

    uart_buffer_flow_checksum DUT (
        .clk(clk), .nrst(nrst), .cfg(cfg), .txWrite(txWrite), .txWriteData(txData),
        .rxRead(rxRead), .rxFlush(rxFlush), .txFlush(txFlush), .clearTxWriteError(clrWriteErr),
        .clearOverflow(clrOvf), .clearCollision(clrCol), .clearTxChecksum(clrTxSum),
        .clearRxChecksum(clrRxSum), .rxWordDone(rxWordDone), .rxWord(rxWord),
        .txCharDone(txCharDone), .daliMidBitMissing(daliMiss), .rxShiftRun(rxShiftRun),
        .txStart(txStart), .txShiftData(txShiftData), .txActive(txActive), .ctsN(ctsN),
        .rtsN(rtsN), .txDriveEnable(tx_drive_enable), .rxData(rxData), .txChecksum(txSum),
        .rxChecksum(rxSum), .status(status));
    ubfc_partner #(.CHAR_CYCLES(4)) PEER (
        .clk(clk), .nrst(nrst), .txStart(txStart), .txShiftData(txShiftData),
        .ctsN(rtsN),
        .rxWordDone(rxWordDone), .rxWord(rxWord), .txCharDone(txCharDone),
        .sendReq(sendReq), .sendByte(sendByte), .echo(echo), .corrupt(corrupt),
        .lastTx(lastTx));

    // ========================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pls(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pls
    task automatic rx(input logic [7:0] b);
        sendByte = b;
        pls(sendReq);
        tick(2);
    endtask : rx
    task automatic wr(input logic [7:0] b);
        txData = b;
        pls(txWrite);
    endtask : wr
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // ========================================
    // Scenarios
    task automatic t_collide();
        echo = 1'b1;
        wr(8'h5a);
        tick(8);
        chk(status.collisionFlag, 1'b0);
        corrupt = 1'b1;
        wr(8'h5a);
        tick(8);
        chk(status.collisionFlag, 1'b1);
        corrupt = 1'b0;
        pls(rxFlush);
        pls(clrCol);
        cfg.mode = ubfc_pkg::UBFC_DALI;
        wr(8'h3c);
        pls(daliMiss);
        tick(8);
        chk(status.collisionFlag, 1'b1);
        cfg.mode = ubfc_pkg::UBFC_ASYNC;
        echo = 1'b0;
        pls(rxFlush);
        $display("done: collision");
    endtask : t_collide
    task automatic t_tx();
        cfg.txEnable = 1'b0;
        wr(8'ha1);
        chk(status.txEmpty, 1'b1);
        wr(8'hb2);
        chk(status.txFull, 1'b1);
        wr(8'hc3);
        chk(status.txWriteError, 1'b1);
        pls(clrWriteErr);
        chk(status.txWriteError, 1'b0);
        pls(txFlush);
        chk(status.txFull, 1'b0);
        wr(8'hd4);
        cfg.txEnable = 1'b1;
        tick(10);
        chk(lastTx, 8'hd4);
        wr(8'he5);
        wr(8'hf6);
        pls(txFlush);
        chk(txActive, 1'b1);
        tick(10);
        chk(lastTx, 8'he5);
        $display("done: tx buffer");
    endtask : t_tx
    task automatic t_hw();
        cfg.flowSelect = 2'h2;
        // The second word begins just before ready-to-send rises, so it must still land.
        sendByte = 8'h31;
        sendReq  = 1'b1;
        tick(1);
        sendByte = 8'h32;
        tick(1);
        sendReq  = 1'b0;
        tick(2);
        chk(rtsN, 1'b1);
        chk(status.rxFull, 1'b1);
        rx(8'h33);
        chk(status.rxOverflowFlag, 1'b0);
        cfg.mode = ubfc_pkg::UBFC_DMX;
        tick(1);
        chk(rtsN, 1'b0);
        cfg.mode = ubfc_pkg::UBFC_ASYNC;
        chk(rxData, 8'h31);
        pls(rxRead);
        chk(rtsN, 1'b1);
        chk(rxData, 8'h32);
        pls(rxRead);
        chk(rtsN, 1'b0);
        ctsN = 1'b1;
        wr(8'h47);
        tick(4);
        chk(tx_drive_enable, 1'b0);
        ctsN = 1'b0;
        tick(2);
        chk(tx_drive_enable, 1'b1);
        tick(8);
        chk(lastTx, 8'h47);
        cfg.flowSelect = 2'h0;
        $display("done: hardware flow");
    endtask : t_hw
    task automatic t_xoff();
        cfg.flowSelect = 2'h1;
        rx(8'h13);
        chk(status.xonState, 1'b0);
        wr(8'h58);
        tick(6);
        chk(txActive, 1'b0);
        rx(8'h11);
        tick(8);
        chk(lastTx, 8'h58);
        pls(rxFlush);
        rx(8'h13);
        chk(status.xonState, 1'b0);
        cfg.txEnable = 1'b0;
        tick(1);
        cfg.txEnable = 1'b1;
        tick(1);
        chk(status.xonState, 1'b1);
        $display("done: xon xoff");
    endtask : t_xoff
    task automatic t_ovf();
        pls(rxFlush);
        chk(status.rxEmpty, 1'b1);
        cfg.runDuringOverflow = 1'b1;
        rx(8'h01);
        rx(8'h02);
        rx(8'h13);
        chk({status.rxOverflowFlag, rxShiftRun, status.xonState}, 8'h06);
        pls(rxRead);
        chk(rxData, 8'h02);
        pls(rxFlush);
        pls(clrOvf);
        rx(8'h11);
        cfg.runDuringOverflow = 1'b0;
        rx(8'h01);
        rx(8'h02);
        chk(rxShiftRun, 1'b0);
        pls(rxFlush);
        pls(clrOvf);
        chk(rxShiftRun, 1'b1);
        cfg.flowSelect = 2'h0;
        $display("done: overflow");
    endtask : t_ovf
    task automatic t_sum();
        pls(rxFlush);
        pls(clrTxSum);
        pls(clrRxSum);
        cfg.checksumEnable = 1'b1;
        rx(8'hf0);
        rx(8'h20);
        wr(8'hf0);
        wr(8'h20);
        tick(12);
        chk(rxSum, 8'h11);
        chk(txSum, 8'h11);
        cfg.mode = ubfc_pkg::UBFC_LIN;
        pls(rxFlush);
        rx(8'h05);
        chk(rxSum, 8'h11);
        cfg.mode = ubfc_pkg::UBFC_ASYNC;
        $display("done: checksum");
    endtask : t_sum
    task automatic t_off();
        cfg.txEnable = 1'b0;
        wr(8'h61);
        wr(8'h62);
        rx(8'h63);
        cfg.moduleOn = 1'b0;
        tick(2);
        chk({status.rxEmpty, status.txEmpty}, 8'h03);
        cfg.moduleOn = 1'b1;
        cfg.txEnable = 1'b1;
        tick(8);
        chk(txActive, 1'b0);
        $display("done: module off");
    endtask : t_off

    initial begin
        cfg.moduleOn = 1'b1;
        cfg.txEnable = 1'b1;
        cfg.rxEnable = 1'b1;
        tick(10);
        nrst = 1'b1;
        tick(1);
        chk(status, 8'ha4);
        t_collide();
        t_tx();
        t_hw();
        t_xoff();
        t_ovf();
        t_sum();
        t_off();
        summarize();
    end

    // The tests need some 240 cycles; this limit of 4000 cycles is about 17 times that.
    initial begin
        #200000;
        failCount++;
        summarize();
    end
endmodule : uart_buffer_flow_checksum_test
